// ---- rtl/umx_params.svh ----
// Constants for the multiprocessor serial transceiver
`ifndef UMX_PARAMS_SVH
`define UMX_PARAMS_SVH
`define UMX_CLK_MHZ 100
`define UMX_DEGLITCH_NS 300
`define UMX_DEGLITCH_CYC ((`UMX_DEGLITCH_NS * `UMX_CLK_MHZ + 999) / 1000)
`define UMX_DIV_DEFAULT 16'h0364
`define UMX_IDLE_MARKS 4'hA
`define UMX_WAKE_IDLE_BITS 4'hB
`define UMX_BREAK_LOWS 4'hA
`define UMX_ADDR_CTRL 4'h0
`define UMX_ADDR_STAT 4'h1
`define UMX_ADDR_TXBUF 4'h2
`define UMX_ADDR_RXBUF 4'h3
`define UMX_ADDR_DIV 4'h4
`define UMX_CTRL_RESET 16'h0001
`endif

// ---- rtl/umx_pkg.sv ----
// Types for the multiprocessor serial transceiver
package umx_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} umx_bus_t;
	typedef enum logic [2:0] {
		RX_IDLE = 3'h0,
		RX_GLITCH = 3'h1,
		RX_START = 3'h3,
		RX_BITS = 3'h2,
		RX_STOP = 3'h6,
		RX_BREAK = 3'h7
	} umx_rx_st_t;
	typedef enum logic [1:0] {
		TX_IDLE = 2'h0,
		TX_SHIFT = 2'h1,
		TX_IDLE_GAP = 2'h3
	} umx_tx_st_t;
endpackage

// ---- rtl/umx_core.sv ----
// Multiprocessor serial transceiver core with register port
// Overview of operation
// - Power-up clear resets unit and sets soft reset bit, holding unit reset
// - Soft reset clears interrupt enables, flags, address request and tag, errors; sets ready and empty
// - Frame: start, 7 or 8 data, optional address bit, optional parity, 1 or 2 stops
// - Transmit and receive share one bit rate
// - Idle-line mode: ten marks after first stop bit mean idle line
// - First character after idle is address and sets receive address tag
// - Wake filter drops non-address characters; addresses buffered and flagged
// - Hardware never changes wake filter enable; software clears it
// - Shift load copies address request into wake latch, then clears request
// - Idle-line wake latch sends exactly eleven idle bits, dummy discarded
// - Address-bit mode: extra bit; set bit tags received address
// - Address request copied to address bit, cleared by hardware or reset
// - Receive lows shorter than 300 ns are ignored
// - Start bit and each data bit are majority voted; failed start abandons
// - Low first stop bit sets framing fault; second stop unchecked
// - Parity mismatch flagged; address bit included in parity
// - Loading receive buffer before prior read sets overrun
// - Ten lows after all-zero character with missing stop bit set break flag; receive flag only with error accept on
// - Error accept off: faulty characters not stored; on: stored and flagged
// - Summary error follows any flag; flags held until cleared or buffer read
// - Data shifted least significant bit first both directions
// - Vote samples at N/2-1, N/2, N/2+1 clock cycles into the bit
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "umx_params.svh"
module umx_core #(
	parameter logic [15:0] DIV_DEFAULT = `UMX_DIV_DEFAULT
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Register port
	input wire umx_pkg::umx_bus_t bus,
	output logic [15:0] rdata,
	// Serial pins
	input wire logic serial_rx_pin,
	output logic serial_tx_pin,
	// Status outputs
	output logic rx_int_flag,
	output logic tx_ready_flag,
	output logic rx_int_enable,
	output logic tx_int_enable
);
	import umx_pkg::*;
	// Control fields
	logic soft_reset_bit_q, rx_enable_bit_q, tx_enable_bit_q;
	logic multiproc_format_sel_q, rx_wake_filter_enable_q, rx_error_accept_enable_q;
	logic char8_q, parity_en_q, parity_even_q, stop2_q;
	logic rx_int_enable_q, tx_int_enable_q;
	logic [15:0] div_q;
	// Status
	logic tx_address_request_q, wake_temp_latch_q, tx_ready_flag_q, tx_empty_flag_q;
	logic rx_int_flag_q, rx_address_tag_q;
	logic break_flag_q, parity_mismatch_flag_q, framing_fault_flag_q, overrun_flag_q;
	logic [7:0] tx_buffer_q, rx_buffer_q;
	logic [15:0] rdata_q;
	logic rx_any_error;
	logic wr_ctrl, wr_tx, rd_rx, wr_stat;

	assign wr_ctrl = bus.wr && bus.addr == `UMX_ADDR_CTRL;
	assign wr_stat = bus.wr && bus.addr == `UMX_ADDR_STAT;
	assign wr_tx = bus.wr && bus.addr == `UMX_ADDR_TXBUF;
	assign rd_rx = bus.rd && bus.addr == `UMX_ADDR_RXBUF;
	assign rx_any_error = break_flag_q | parity_mismatch_flag_q
		| framing_fault_flag_q | overrun_flag_q;

	// Control register; power-up clear sets soft reset
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			soft_reset_bit_q <= 1'b1;
			{rx_enable_bit_q, tx_enable_bit_q, multiproc_format_sel_q} <= 3'h0;
			{rx_wake_filter_enable_q, rx_error_accept_enable_q} <= 2'h0;
			{char8_q, parity_en_q, parity_even_q, stop2_q} <= 4'h0;
			{rx_int_enable_q, tx_int_enable_q} <= 2'h0;
			div_q <= DIV_DEFAULT;
		end else begin
			if (wr_ctrl) begin
				// Hardware never touches the wake filter bit
				soft_reset_bit_q <= bus.wdata[0];
				rx_enable_bit_q <= bus.wdata[1];
				tx_enable_bit_q <= bus.wdata[2];
				multiproc_format_sel_q <= bus.wdata[3];
				rx_wake_filter_enable_q <= bus.wdata[4];
				rx_error_accept_enable_q <= bus.wdata[5];
				char8_q <= bus.wdata[6];
				parity_en_q <= bus.wdata[7];
				parity_even_q <= bus.wdata[8];
				stop2_q <= bus.wdata[9];
				rx_int_enable_q <= bus.wdata[10];
				tx_int_enable_q <= bus.wdata[11];
			end
			// Enables cleared by soft reset, rx/tx enables kept
			if (soft_reset_bit_q) begin
				rx_int_enable_q <= 1'b0;
				tx_int_enable_q <= 1'b0;
			end
			if (bus.wr && bus.addr == `UMX_ADDR_DIV) begin
				div_q <= bus.wdata;
			end
		end
	end

	// Shared bit-rate divisor and half-bit count: one rate for both paths
	logic [15:0] half;
	assign half = {1'b0, div_q[15:1]};

	// Input synchroniser and deglitch filter
	logic rx_s1_q, rx_s2_q, rx_f_q;
	logic [7:0] glitch_cnt_q;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
		end else begin
			rx_s1_q <= serial_rx_pin;
			rx_s2_q <= rx_s1_q;
		end
	end

	// Receive state
	umx_rx_st_t rx_st_q;
	logic [15:0] rx_cnt_q;
	logic [3:0] rx_bit_q, rx_nbits, low_cnt_q, mark_cnt_q;
	logic [1:0] votes_q;
	logic [10:0] rx_sh_q;
	logic idle_seen_q, vote, rx_done, rx_addr, rx_perr, rx_ferr;
	assign vote = (votes_q[0] & votes_q[1]) | (votes_q[0] & rx_s2_q)
		| (votes_q[1] & rx_s2_q);
	// Character length after start: data, address, parity
	assign rx_nbits = 4'(char8_q ? 8 : 7) + 4'(multiproc_format_sel_q) + 4'(parity_en_q);

	// Receiver sequencer; samples at N/2-1, N/2, N/2+1
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rx_st_q <= RX_IDLE;
			rx_cnt_q <= 16'h0000;
			rx_bit_q <= 4'h0;
			votes_q <= 2'h3;
			rx_sh_q <= 11'h000;
			glitch_cnt_q <= 8'h00;
			low_cnt_q <= 4'h0;
		end else if (soft_reset_bit_q || !rx_enable_bit_q) begin
			rx_st_q <= RX_IDLE;
		end else begin
			rx_cnt_q <= rx_cnt_q + 16'h0001;
			if (rx_cnt_q == half - 16'h0001) votes_q[0] <= rx_s2_q;
			if (rx_cnt_q == half) votes_q[1] <= rx_s2_q;
			case (rx_st_q)
				RX_IDLE: begin
					glitch_cnt_q <= 8'h00;
					if (!rx_s2_q) rx_cnt_q <= 16'h0000; // Runs on in idle to time marks
					if (!rx_s2_q) rx_st_q <= RX_GLITCH;
				end
				RX_GLITCH: begin
					// Short lows never start a character
					glitch_cnt_q <= glitch_cnt_q + 8'h01;
					if (rx_s2_q) rx_st_q <= RX_IDLE;
					else if (glitch_cnt_q == 8'(`UMX_DEGLITCH_CYC)) rx_st_q <= RX_START;
				end
				RX_START: begin
					if (rx_cnt_q == half + 16'h0001) begin
						// Failed start vote abandons reception
						rx_st_q <= vote ? RX_IDLE : RX_BITS;
						rx_bit_q <= 4'h0;
					end
				end
				RX_BITS: begin
					if (rx_cnt_q == half + 16'h0001) begin
						// LSB arrives first, shifts down
						rx_sh_q <= {vote, rx_sh_q[10:1]};
						rx_bit_q <= rx_bit_q + 4'h1;
						if (rx_bit_q == rx_nbits - 4'h1) rx_st_q <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_cnt_q == half + 16'h0001) begin
						low_cnt_q <= 4'h0;
						rx_st_q <= (!vote && rx_al == 11'h000) ? RX_BREAK : RX_IDLE;
					end
				end
				RX_BREAK: begin
					// Count further low bits until line rises
					if (rx_s2_q) rx_st_q <= RX_IDLE;
					else if (rx_cnt_q == half + 16'h0001 && low_cnt_q != 4'hF)
						low_cnt_q <= low_cnt_q + 4'h1;
				end
				default: rx_st_q <= RX_IDLE;
			endcase
			if (rx_cnt_q == div_q - 16'h0001) rx_cnt_q <= 16'h0000;
		end
	end

	// Character aligned to bit 0 after shifting; extract fields
	logic [10:0] rx_al;
	logic [7:0] rx_data;
	assign rx_al = rx_sh_q >> (4'd11 - rx_nbits);
	assign rx_data = char8_q ? rx_al[7:0] : {1'b0, rx_al[6:0]};
	assign rx_addr = multiproc_format_sel_q ? rx_al[char8_q ? 8 : 7] : idle_seen_q;
	// Parity covers data and address bit
	assign rx_perr = parity_en_q && ((^rx_al[rx_nbits - 4'h1 -: 1] ^ ^(rx_al & ~(11'h001 <<
		(rx_nbits - 4'h1))) ^ ~parity_even_q) == 1'b1);
	assign rx_ferr = rx_st_q == RX_STOP && !vote;
	assign rx_done = rx_st_q == RX_STOP && rx_cnt_q == half + 16'h0001;
	logic brk_hit;
	assign brk_hit = rx_st_q == RX_BREAK && low_cnt_q == `UMX_BREAK_LOWS - 4'h1
		&& rx_cnt_q == half + 16'h0001;

	// Idle-line detector: marks after first stop bit
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mark_cnt_q <= 4'h0;
			idle_seen_q <= 1'b0;
		end else if (rx_st_q != RX_IDLE || !rx_s2_q || soft_reset_bit_q || !rx_enable_bit_q) begin
			mark_cnt_q <= 4'h0;
			if (rx_done) idle_seen_q <= 1'b0;
		end else if (rx_cnt_q == half + 16'h0001 && mark_cnt_q != `UMX_IDLE_MARKS) begin
			mark_cnt_q <= mark_cnt_q + 4'h1;
			if (mark_cnt_q == `UMX_IDLE_MARKS - 4'h1) idle_seen_q <= 1'b1;
		end
	end

	// Receive buffer and flags; set wins over clear
	logic accept, store, any_err;
	assign any_err = rx_ferr | rx_perr;
	assign accept = rx_done && (!rx_wake_filter_enable_q || rx_addr);
	assign store = accept && (rx_error_accept_enable_q || !any_err);
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rx_buffer_q <= 8'h00;
			{rx_int_flag_q, rx_address_tag_q, overrun_flag_q} <= 3'h0;
			{break_flag_q, parity_mismatch_flag_q, framing_fault_flag_q} <= 3'h0;
		end else if (soft_reset_bit_q) begin
			rx_int_flag_q <= 1'b0;
			rx_address_tag_q <= 1'b0;
			{break_flag_q, parity_mismatch_flag_q, framing_fault_flag_q} <= 3'h0;
			overrun_flag_q <= 1'b0;
		end else begin
			// Buffer read clears flags; status write clears error flags written as ones
			if (rd_rx) begin
				rx_int_flag_q <= 1'b0;
				{break_flag_q, parity_mismatch_flag_q, framing_fault_flag_q} <= 3'h0;
				overrun_flag_q <= 1'b0;
			end
			if (wr_stat) begin
				break_flag_q <= break_flag_q & ~bus.wdata[3];
				parity_mismatch_flag_q <= parity_mismatch_flag_q & ~bus.wdata[4];
				framing_fault_flag_q <= framing_fault_flag_q & ~bus.wdata[5];
				overrun_flag_q <= overrun_flag_q & ~bus.wdata[6];
			end
			if (accept) begin
				if (rx_ferr) framing_fault_flag_q <= 1'b1;
				if (rx_perr) parity_mismatch_flag_q <= 1'b1;
			end
			if (store) begin
				if (rx_int_flag_q && !rd_rx) overrun_flag_q <= 1'b1;
				rx_buffer_q <= rx_data;
				rx_int_flag_q <= 1'b1;
				rx_address_tag_q <= rx_addr;
			end
			if (brk_hit) begin
				break_flag_q <= 1'b1;
				if (rx_error_accept_enable_q) rx_int_flag_q <= 1'b1;
			end
		end
	end

	// Transmitter
	umx_tx_st_t tx_st_q;
	logic [15:0] tx_cnt_q;
	logic [3:0] tx_bit_q, tx_total;
	logic [12:0] tx_sh_q;
	logic tx_par, tx_bit_end, tx_pin_q;
	assign tx_bit_end = tx_cnt_q == div_q - 16'h0001;
	// Start + data + addr + parity + stops
	assign tx_total = 4'h1 + rx_nbits + (stop2_q ? 4'h2 : 4'h1);
	assign tx_par = ^(char8_q ? tx_buffer_q : {1'b0, tx_buffer_q[6:0]})
		^ (multiproc_format_sel_q & tx_address_request_q) ^ ~parity_even_q;
	logic [12:0] tx_frame;
	always_comb begin
		logic [10:0] body;
		body = char8_q ? {3'h0, tx_buffer_q} : {4'h0, tx_buffer_q[6:0]};
		if (multiproc_format_sel_q)
			body = body | (11'(tx_address_request_q) << (char8_q ? 8 : 7));
		if (parity_en_q)
			body = body | (11'(tx_par) << (rx_nbits - 4'h1));
		// Stop bits and idle above the frame are marks
		tx_frame = {1'b1, body, 1'b0} | ~(13'h1FFF >> (4'd12 - rx_nbits));
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tx_st_q <= TX_IDLE;
			tx_cnt_q <= 16'h0000;
			tx_bit_q <= 4'h0;
			tx_sh_q <= 13'h1FFF;
			tx_pin_q <= 1'b1;
			tx_ready_flag_q <= 1'b1;
			tx_empty_flag_q <= 1'b1;
			tx_address_request_q <= 1'b0;
			wake_temp_latch_q <= 1'b0;
			tx_buffer_q <= 8'h00;
		end else if (soft_reset_bit_q) begin
			tx_st_q <= TX_IDLE;
			tx_pin_q <= 1'b1;
			tx_ready_flag_q <= 1'b1;
			tx_empty_flag_q <= 1'b1;
			tx_address_request_q <= 1'b0;
			if (wr_tx) tx_buffer_q <= bus.wdata[7:0];
		end else begin
			if (wr_tx) begin
				tx_buffer_q <= bus.wdata[7:0];
				tx_ready_flag_q <= 1'b0;
				tx_empty_flag_q <= 1'b0;
			end
			tx_cnt_q <= tx_bit_end ? 16'h0000 : tx_cnt_q + 16'h0001;
			case (tx_st_q)
				TX_IDLE: begin
					tx_pin_q <= 1'b1;
					if (!tx_ready_flag_q && tx_enable_bit_q && !wr_tx) begin
						// Load shifter, move request into wake latch
						wake_temp_latch_q <= tx_address_request_q;
						tx_address_request_q <= 1'b0;
						tx_ready_flag_q <= 1'b1;
						tx_cnt_q <= 16'h0000;
						tx_bit_q <= 4'h0;
						tx_sh_q <= tx_frame;
						if (tx_address_request_q && !multiproc_format_sel_q) begin
							tx_st_q <= TX_IDLE_GAP; // Dummy discarded
						end else begin
							tx_st_q <= TX_SHIFT;
							tx_pin_q <= 1'b0;
						end
					end else if (tx_ready_flag_q) begin
						tx_empty_flag_q <= 1'b1;
					end
				end
				TX_SHIFT: begin
					if (tx_bit_end) begin
						tx_sh_q <= {1'b1, tx_sh_q[12:1]};
						tx_pin_q <= tx_sh_q[1];
						tx_bit_q <= tx_bit_q + 4'h1;
						if (tx_bit_q == tx_total - 4'h1) tx_st_q <= TX_IDLE;
					end
				end
				TX_IDLE_GAP: begin
					// Exactly eleven mark bits on the line
					tx_pin_q <= 1'b1;
					if (tx_bit_end) begin
						tx_bit_q <= tx_bit_q + 4'h1;
						if (tx_bit_q == `UMX_WAKE_IDLE_BITS - 4'h1) tx_st_q <= TX_IDLE;
					end
				end
				default: tx_st_q <= TX_IDLE;
			endcase
			if (wr_stat && bus.wdata[0]) tx_address_request_q <= 1'b1; // Set beats load clear
		end
	end
	// Register read port, data one cycle after strobe
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 16'h0000;
		end else if (bus.rd) begin
			case (bus.addr)
				`UMX_ADDR_CTRL: rdata_q <= {4'h0, tx_int_enable_q, rx_int_enable_q, stop2_q,
					parity_even_q, parity_en_q, char8_q, rx_error_accept_enable_q,
					rx_wake_filter_enable_q, multiproc_format_sel_q, tx_enable_bit_q,
					rx_enable_bit_q, soft_reset_bit_q};
				`UMX_ADDR_STAT: rdata_q <= {6'h00, tx_empty_flag_q, tx_ready_flag_q,
					rx_int_flag_q, overrun_flag_q, framing_fault_flag_q,
					parity_mismatch_flag_q, break_flag_q, rx_any_error,
					rx_address_tag_q, tx_address_request_q};
				`UMX_ADDR_RXBUF: rdata_q <= {8'h00, rx_buffer_q};
				`UMX_ADDR_TXBUF: rdata_q <= {8'h00, tx_buffer_q};
				`UMX_ADDR_DIV: rdata_q <= div_q;
				default: rdata_q <= 16'h0000;
			endcase
		end else begin
			rdata_q <= 16'h0000;
		end
	end

	// Outputs from flops
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			{rx_int_flag, tx_ready_flag, rx_int_enable, tx_int_enable} <= 4'h4;
		end else begin
			rx_int_flag <= rx_int_flag_q;
			tx_ready_flag <= tx_ready_flag_q;
			rx_int_enable <= rx_int_enable_q;
			tx_int_enable <= tx_int_enable_q;
		end
	end
	assign rdata = rdata_q;
	assign serial_tx_pin = tx_pin_q;
endmodule // umx_core

// ---- verif/umx_core_properties.sv ----
// Port-level checker for the multiprocessor serial transceiver
`timescale 1ns/1ps
`include "umx_params.svh"
module umx_core_properties #(
	parameter logic [15:0] DIV_DEFAULT = `UMX_DIV_DEFAULT
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Register port
	input wire umx_pkg::umx_bus_t bus,
	input wire logic [15:0] rdata,
	// Serial pins
	input wire logic serial_rx_pin,
	input wire logic serial_tx_pin,
	// Status outputs
	input wire logic rx_int_flag,
	input wire logic tx_ready_flag,
	input wire logic rx_int_enable,
	input wire logic tx_int_enable
);
	import umx_pkg::*;
	localparam logic [15:0] MAX_LOW = 16'(DIV_DEFAULT * 11);
	logic [2:0] held_q;
	logic [1:0] rx_clr_q;
	logic [1:0] tx_wr_q;
	logic [15:0] low_len_q;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// Soft reset history; outputs lag the write by up to three cycles
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) held_q <= 3'h7;
		else if (bus.wr && bus.addr == `UMX_ADDR_CTRL) held_q <= {held_q[1:0], bus.wdata[0]};
		else held_q <= {held_q[1:0], held_q[0]};
	end
	// Recent causes that may drop the receive flag
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) rx_clr_q <= 2'h0;
		else if (bus.rd && bus.addr == `UMX_ADDR_RXBUF) rx_clr_q <= 2'h3;
		else if (bus.wr && bus.addr == `UMX_ADDR_CTRL && bus.wdata[0]) rx_clr_q <= 2'h3;
		else if (rx_clr_q != 2'h0) rx_clr_q <= rx_clr_q - 2'h1;
	end
	// Recent transmit buffer writes
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) tx_wr_q <= 2'h0;
		else if (bus.wr && bus.addr == `UMX_ADDR_TXBUF) tx_wr_q <= 2'h3;
		else if (tx_wr_q != 2'h0) tx_wr_q <= tx_wr_q - 2'h1;
	end
	// Length of the current low run on the transmit line
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) low_len_q <= 16'h0000;
		else if (!serial_tx_pin) low_len_q <= low_len_q + 16'h0001;
		else low_len_q <= 16'h0000;
	end
	a_reset_idle: assert property ($rose(resetn) |-> serial_tx_pin && tx_ready_flag && !rx_int_flag)
		else $error("outputs not idle after reset");
	a_soft_hold: assert property (&held_q |-> serial_tx_pin && tx_ready_flag && !rx_int_flag
		&& !rx_int_enable && !tx_int_enable)
		else $error("soft reset state not held at outputs");
	a_tx_bit_time: assert property ($rose(serial_tx_pin) |-> (low_len_q % DIV_DEFAULT) == 16'h0000)
		else $error("transmit low run not whole bit periods");
	a_tx_low_bound: assert property (low_len_q <= MAX_LOW)
		else $error("transmit line low longer than a character");
	a_err_summary: assert property ($past(bus.rd) && $past(bus.addr) == `UMX_ADDR_STAT
		|-> rdata[2] == |rdata[6:3])
		else $error("summary error disagrees with error flags");
	a_stat_mirror: assert property ($past(bus.rd) && $past(bus.addr) == `UMX_ADDR_STAT
		|-> rdata[7] == rx_int_flag && rdata[8] == tx_ready_flag)
		else $error("status flags disagree with flag outputs");
	a_rx_clear_cause: assert property ($fell(rx_int_flag) |-> rx_clr_q != 2'h0)
		else $error("receive flag dropped without read or reset");
	a_ready_fall: assert property ($fell(tx_ready_flag) |-> tx_wr_q != 2'h0)
		else $error("transmit ready dropped without buffer write");
endmodule // umx_core_properties

bind umx_core umx_core_properties #(.DIV_DEFAULT(DIV_DEFAULT)) i_umx_core_properties (
	.clk_sys(clk_sys), .resetn(resetn), .bus(bus), .rdata(rdata),
	.serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin),
	.rx_int_flag(rx_int_flag), .tx_ready_flag(tx_ready_flag),
	.rx_int_enable(rx_int_enable), .tx_int_enable(tx_int_enable)
);

// ---- verif/umx_remote.sv ----
// Remote serial device model facing the transceiver pins
`timescale 1ns/1ps
module umx_remote #(
	parameter int PER = 100
) (
	// Clock
	input wire logic clk_sys,
	// Serial lines seen from the far side
	input wire logic serial_tx_pin,
	output logic serial_rx_pin
);
	realtime fall_t;
	initial serial_rx_pin = 1'b1;
	// One bit per period, LSB first; line returns to mark afterwards
	task automatic send(input logic [31:0] bits, input int n);
		@(posedge clk_sys);
		for (int i = 0; i < n; i++) begin
			serial_rx_pin <= bits[i];
			repeat (PER) @(posedge clk_sys);
		end
		serial_rx_pin <= 1'b1;
	endtask
	// Short low pulse, for glitch and false start cases
	task automatic pulse_low(input int n);
		@(posedge clk_sys);
		serial_rx_pin <= 1'b0;
		repeat (n) @(posedge clk_sys);
		serial_rx_pin <= 1'b1;
	endtask
	// Mid-bit sampling from the start edge; ok stays clear if nothing starts
	task automatic grab(input int n, output logic [31:0] v, output bit ok);
		v = '0;
		ok = 0;
		for (int k = 0; k < 20 * PER && serial_tx_pin !== 1'b0; k++) @(posedge clk_sys);
		if (serial_tx_pin === 1'b0) begin
			ok = 1;
			fall_t = $realtime;
			repeat (PER / 2) @(posedge clk_sys);
			for (int i = 0; i < n; i++) begin
				v[i] = serial_tx_pin;
				repeat (PER) @(posedge clk_sys);
			end
		end
	endtask
endmodule // umx_remote

// ---- verif/umx_core_test.sv ----
// Self-checking bench for the multiprocessor serial transceiver
`timescale 1ns/1ps
`include "umx_params.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fail_count++; $display("FAIL %s expected %h seen %h", nm, ex, got); end end
module umx_core_test;
	import umx_pkg::*;
	localparam int PER = 100;
	localparam logic [15:0] BASE = 16'h01C6;
	logic clk_sys, resetn, serial_rx_pin, serial_tx_pin;
	logic rx_int_flag, tx_ready_flag, rx_int_enable, tx_int_enable;
	umx_bus_t bus;
	logic [15:0] rdata, v;
	logic [31:0] f;
	bit ok;
	int fail_count, compares, cycles;
	realtime t0;
	umx_core #(.DIV_DEFAULT(16'h0064)) i_umx_core (.clk_sys(clk_sys), .resetn(resetn), .bus(bus),
		.rdata(rdata), .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin),
		.rx_int_flag(rx_int_flag), .tx_ready_flag(tx_ready_flag),
		.rx_int_enable(rx_int_enable), .tx_int_enable(tx_int_enable));
	umx_remote #(.PER(PER)) i_umx_remote (.clk_sys(clk_sys), .serial_tx_pin(serial_tx_pin),
		.serial_rx_pin(serial_rx_pin));
	initial clk_sys = 1'b0;
	always #5 clk_sys = ~clk_sys;
	// Bus cycles: one-cycle strobes, read data taken in the following cycle
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// Reprogram only under soft reset, as software must
	task automatic cfg(input logic [15:0] c);
		wr(`UMX_ADDR_CTRL, c | 16'h0001);
		wr(`UMX_ADDR_CTRL, c);
	endtask
	task automatic wait_rx();
		for (int k = 0; k < 2 * PER && rx_int_flag !== 1'b1; k++) @(negedge clk_sys);
	endtask
	// Wire order: start, data LSB first, address bit, even parity, stop
	function automatic logic [31:0] frame(input logic [7:0] d, input bit abit, input bit ad);
		logic p;
		p = ^d ^ (abit & ad);
		return abit ? {20'h0_0000, 1'b1, p, ad, d, 1'b0} : {21'h00_0000, 1'b1, p, d, 1'b0};
	endfunction
	task automatic t_reset();
		rd(`UMX_ADDR_CTRL, v);
		`CHK("ctrl_after_reset", `UMX_CTRL_RESET, v)
		wr(`UMX_ADDR_CTRL, 16'h0C07);
		tick(3);
		rd(`UMX_ADDR_CTRL, v);
		`CHK("ctrl_held", 16'h0007, v)
		rd(`UMX_ADDR_STAT, v);
		`CHK("stat_held", 16'h0300, v)
	endtask
	task automatic t_tx();
		logic [7:0] vals [3] = '{8'hA5, 8'h3C, 8'h01};
		cfg(BASE);
		for (int i = 0; i < 3; i++) begin
			wr(`UMX_ADDR_TXBUF, {8'h00, vals[i]});
			i_umx_remote.grab(11, f, ok);
			`CHK("tx_frame", frame(vals[i], 0, 0), f)
		end
		cfg(BASE | 16'h0008);
		wr(`UMX_ADDR_STAT, 16'h0001);
		wr(`UMX_ADDR_TXBUF, 16'h003C);
		i_umx_remote.grab(12, f, ok);
		`CHK("tx_addr_frame", frame(8'h3C, 1, 1), f)
		rd(`UMX_ADDR_STAT, v);
		`CHK("req_cleared_empty", 2'b10, {v[9], v[0]})
		wr(`UMX_ADDR_TXBUF, 16'h00C3);
		i_umx_remote.grab(12, f, ok);
		`CHK("tx_data_frame", frame(8'hC3, 1, 0), f)
	endtask
	// Dummy write with address request gives an eleven-bit idle gap
	task automatic t_tx_wake();
		cfg(BASE);
		wr(`UMX_ADDR_STAT, 16'h0001);
		t0 = $realtime;
		wr(`UMX_ADDR_TXBUF, 16'h00FF);
		tick(4);
		for (int k = 0; k < 2 * PER && tx_ready_flag !== 1'b1; k++) @(negedge clk_sys);
		rd(`UMX_ADDR_STAT, v);
		`CHK("req_moved", 1'b0, v[0])
		wr(`UMX_ADDR_TXBUF, 16'h0081);
		i_umx_remote.grab(11, f, ok);
		`CHK("addr_after_gap", frame(8'h81, 0, 0), f)
		ok = ((i_umx_remote.fall_t - t0) >= 110.0 * PER) && ((i_umx_remote.fall_t - t0) < 120.0 * PER);
		`CHK("idle_gap", 1'b1, ok)
	endtask
	task automatic t_rx();
		cfg(BASE | 16'h0020);
		i_umx_remote.pulse_low(20);
		i_umx_remote.pulse_low(40); // Past deglitch, high again before the vote
		tick(12 * PER);
		`CHK("no_false_start", 1'b0, rx_int_flag)
		i_umx_remote.send(frame(8'h5A, 0, 0), 11);
		wait_rx();
		rd(`UMX_ADDR_STAT, v);
		`CHK("first_is_addr", 7'h41, v[7:1])
		rd(`UMX_ADDR_RXBUF, v);
		`CHK("rx_byte", 16'h005A, v)
		i_umx_remote.send(frame(8'hC3, 0, 0), 11);
		wait_rx();
		rd(`UMX_ADDR_STAT, v);
		`CHK("next_is_data", 7'h40, v[7:1])
		rd(`UMX_ADDR_RXBUF, v);
		`CHK("rx_byte2", 16'h00C3, v)
		i_umx_remote.send(frame(8'h11, 0, 0), 11);
		i_umx_remote.send(frame(8'h22, 0, 0), 11);
		wait_rx();
		rd(`UMX_ADDR_STAT, v);
		`CHK("overrun", 2'b11, {v[6], v[2]})
		rd(`UMX_ADDR_RXBUF, v);
		`CHK("newest_kept", 16'h0022, v)
		rd(`UMX_ADDR_STAT, v);
		`CHK("read_clears", 5'h00, v[6:2])
	endtask
	task automatic t_rx_errors();
		f = frame(8'h33, 0, 0);
		f[9] = ~f[9];
		i_umx_remote.send(f, 11);
		wait_rx();
		rd(`UMX_ADDR_STAT, v);
		`CHK("parity_err", 3'b111, {v[7], v[4], v[2]})
		rd(`UMX_ADDR_RXBUF, v);
		`CHK("bad_char_kept", 16'h0033, v)
		cfg(BASE);
		f = frame(8'h44, 0, 0);
		f[10] = 1'b0;
		i_umx_remote.send(f, 11);
		tick(2 * PER);
		`CHK("bad_char_dropped", 1'b0, rx_int_flag)
		rd(`UMX_ADDR_STAT, v);
		`CHK("framing_err", 2'b11, {v[5], v[2]})
		wr(`UMX_ADDR_STAT, 16'h0020);
		rd(`UMX_ADDR_STAT, v);
		`CHK("err_cleared", 4'h0, {v[5:4], v[2], v[7]})
		cfg(BASE | 16'h0020);
		i_umx_remote.send(32'h0000_0000, 21);
		wait_rx();
		rd(`UMX_ADDR_STAT, v);
		`CHK("break", 3'b111, {v[7], v[3], v[2]})
		wr(`UMX_ADDR_CTRL, BASE | 16'h0021);
		rd(`UMX_ADDR_STAT, v);
		`CHK("soft_reset_clears", 16'h0300, v)
	endtask
	task automatic t_wake_filter();
		cfg(BASE | 16'h0038);
		i_umx_remote.send(frame(8'h12, 1, 0), 12);
		tick(2 * PER);
		`CHK("data_filtered", 1'b0, rx_int_flag)
		i_umx_remote.send(frame(8'h34, 1, 1), 12);
		wait_rx();
		rd(`UMX_ADDR_STAT, v);
		`CHK("addr_tagged", 2'b11, {v[7], v[1]})
		rd(`UMX_ADDR_CTRL, v);
		`CHK("filter_kept", 1'b1, v[4])
		rd(`UMX_ADDR_RXBUF, v);
		`CHK("addr_byte", 16'h0034, v)
		wr(`UMX_ADDR_CTRL, BASE | 16'h0028);
		i_umx_remote.send(frame(8'h56, 1, 0), 12);
		wait_rx();
		rd(`UMX_ADDR_RXBUF, v);
		`CHK("data_after_unfilter", 16'h0056, v)
	endtask
	// Seven data bits, odd parity, two stops; buffer bit 7 must not reach the line
	task automatic t_modes();
		cfg(16'h0286);
		wr(`UMX_ADDR_TXBUF, 16'h00D5);
		i_umx_remote.grab(11, f, ok);
		`CHK("tx_7bit_odd", 32'h0000_07AA, f)
		i_umx_remote.send(32'h0000_07AA, 11);
		wait_rx();
		rd(`UMX_ADDR_STAT, v);
		`CHK("rx_7bit_flags", 2'b10, {v[7], v[2]})
		rd(`UMX_ADDR_RXBUF, v);
		`CHK("rx_7bit_byte", 16'h0055, v)
	endtask
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Hang guard well above the expected run length
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			fail_count++;
			close_out();
		end
	end
	initial begin
		bus = '0;
		resetn = 1'b0;
		fail_count = 0;
		compares = 0;
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		t_reset();
		t_tx();
		t_tx_wake();
		t_rx();
		t_rx_errors();
		t_wake_filter();
		t_modes();
		close_out();
	end
endmodule // umx_core_test
